// *** include/hbps_params.svh ***
// Constants for the H-bridge PWM output steering block.
`ifndef HBPS_PARAMS_SVH
`define HBPS_PARAMS_SVH
`define HBPS_ADDR_W 5
`define HBPS_CH_CFG_BASE 5'h00
`define HBPS_DUTY_BASE 5'h08
`define HBPS_CTRL_ADDR 5'h10
`define HBPS_PERIOD_ADDR 5'h11
`define HBPS_CFG_RESET 8'h00
`define HBPS_DUTY_RESET 16'h0000
`define HBPS_PERIOD_RESET 11'h000
`define HBPS_CFG_OM_POS 6
`define HBPS_CFG_AM_POS 4
`define HBPS_DUTY_POL_POS 0
`define HBPS_CTRL_SIDE_POS 0
`define HBPS_CTRL_SHORT_POS 1
`define HBPS_UNMAPPED_READ 16'h0000
`endif

// *** include/hbps_pkg.sv ***
// Types for the H-bridge PWM output steering block.
package hbps_pkg;
	typedef enum logic [1:0] {
		HBPS_OM_HALF_MINUS,
		HBPS_OM_HALF_PLUS,
		HBPS_OM_FULL,
		HBPS_OM_DUAL
	} hbps_omode_type;
	typedef enum logic [1:0] {
		HBPS_AM_OFF,
		HBPS_AM_LEFT,
		HBPS_AM_RIGHT,
		HBPS_AM_CENTER
	} hbps_amode_type;
endpackage : hbps_pkg

// *** hdl/hbps_wave.sv ***
// Left aligned PWM waveform generator for one channel.
`timescale 1ns/1ps
module hbps_wave (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic [10:0] count,
	input wire logic [10:0] duty,
	output logic active
);
	logic next_active;

	always_comb
	begin
		next_active = enable && (count < duty);
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			active <= 1'b0;
		else
			active <= next_active;
	end
endmodule : hbps_wave

// *** hdl/hbps_steer.sv ***
// Pin steering for one channel from its mode, sign and PWM phase.
`timescale 1ns/1ps
`include "hbps_params.svh"
module hbps_steer (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic full_mode,
	input wire logic half_plus,
	input wire logic polarity,
	input wire logic side_sel_a,
	input wire logic active,
	output logic plus_o,
	output logic plus_oe,
	output logic minus_o,
	output logic minus_oe
);
	logic pwm_lvl;
	logic pwm_on_plus;
	logic next_plus_o;
	logic next_plus_oe;
	logic next_minus_o;
	logic next_minus_oe;

	always_comb
	begin
		pwm_lvl = side_sel_a ? active : ~active;
		pwm_on_plus = polarity ^ side_sel_a;
		next_plus_o = 1'b0;
		next_plus_oe = 1'b0;
		next_minus_o = 1'b0;
		next_minus_oe = 1'b0;
		if (enable)
		begin
			if (full_mode)
			begin
				next_plus_oe = 1'b1;
				next_minus_oe = 1'b1;
				next_plus_o = pwm_on_plus ? pwm_lvl : ~side_sel_a;
				next_minus_o = pwm_on_plus ? ~side_sel_a : pwm_lvl;
			end
			else
			begin
				next_plus_oe = half_plus;
				next_minus_oe = ~half_plus;
				next_plus_o = half_plus ? ~active : 1'b0;
				next_minus_o = half_plus ? 1'b0 : ~active;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			plus_o <= 1'b0;
			plus_oe <= 1'b0;
			minus_o <= 1'b0;
			minus_oe <= 1'b0;
		end
		else
		begin
			plus_o <= next_plus_o;
			plus_oe <= next_plus_oe;
			minus_o <= next_minus_o;
			minus_oe <= next_minus_oe;
		end
	end
endmodule : hbps_steer

// *** hdl/hbps_top.sv ***
// Eight-channel H-bridge PWM controller with output steering.
// Functional notes
// - After reset all channels are disabled and every pin is released.
// - Full modes: one pin PWM, other static; half mode: other pin released.
// - Pair n holds channels 2n and 2n+1 on its first and second pin sets.
// - Full modes: sign bit together with side select picks the PWM pin.
// - Half mode ignores the sign bit; output mode picks the PWM pin.
// - Dual full only when both channels enabled and both select mode 11.
// - A lone dual full channel runs as full bridge; partner as programmed.
// - Duty is bits 10:0 in long format, bits 8:2 in short format.
// - Short format: a high byte write alone is a complete duty update.
// - Dual mode copies written duties to working duties at the first overflow after an odd duty write.
// - Repeated even duty writes before transfer keep only the latest value.
// - Mode 10: channels independent, working duty reloads every overflow.
// - Modes 00 and 01: independent channels, one pin PWM, other released.
// - A released pin is never driven by this block.
// - Output mode codes: 00 half minus, 01 half plus, 10 full, 11 dual.
// - Full modes: static pin high when side select 0, low when 1.
// - Full modes: side select 1 inverts sign meaning and makes PWM active high.
// - Dual pair loads working duties on overflow only after odd duty write.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "hbps_params.svh"
module hbps_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [`HBPS_ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [1:0] wbe,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic [7:0] plus_o,
	output logic [7:0] plus_oe,
	output logic [7:0] minus_o,
	output logic [7:0] minus_oe
);
	logic [7:0] cfg [8];
	logic [7:0] next_cfg [8];
	logic [7:0] wcfg [8];
	logic [7:0] next_wcfg [8];
	logic [15:0] duty [8];
	logic [15:0] next_duty [8];
	logic [10:0] wduty [8];
	logic [10:0] next_wduty [8];
	logic [7:0] wpol;
	logic [7:0] next_wpol;
	logic [3:0] odd_written;
	logic [3:0] next_odd_written;
	logic side_sel_a;
	logic next_side_sel_a;
	logic short_duty_format;
	logic next_short_duty_format;
	logic [10:0] period;
	logic [10:0] next_period;
	logic [10:0] count;
	logic [10:0] next_count;
	logic [15:0] next_rdata;
	logic overflow;
	logic [7:0] ch_en;
	logic [7:0] ch_full;
	logic [7:0] ch_dual;
	logic [7:0] ch_active;

	// Extracts the duty count from a stored word.
	function automatic logic [10:0] duty_value(input logic [15:0] w);
		duty_value = w[15:5];
	endfunction : duty_value

	function automatic logic [1:0] omode(input logic [7:0] c);
		omode = c[`HBPS_CFG_OM_POS+:2];
	endfunction : omode

	function automatic logic ch_enabled(input logic [7:0] c);
		ch_enabled = c[`HBPS_CFG_AM_POS+:2] != hbps_pkg::HBPS_AM_OFF;
	endfunction : ch_enabled

	// ----------------------------------------------------------------
	// Register writes and the timer.
	// ----------------------------------------------------------------
	always_comb
	begin
		next_side_sel_a = side_sel_a;
		next_short_duty_format = short_duty_format;
		next_period = period;
		next_odd_written = odd_written;
		next_rdata = `HBPS_UNMAPPED_READ;
		overflow = (period != 11'h000) && (count >= period - 11'h001);
		next_count = (period == 11'h000 || overflow) ? 11'h000 : count + 11'h001;
		if (overflow)
			next_odd_written = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			next_cfg[i] = cfg[i];
			next_duty[i] = duty[i];
		end
		if (wr)
		begin
			if (addr == `HBPS_CTRL_ADDR)
			begin
				next_side_sel_a = wdata[`HBPS_CTRL_SIDE_POS];
				next_short_duty_format = wdata[`HBPS_CTRL_SHORT_POS];
			end
			if (addr == `HBPS_PERIOD_ADDR)
				next_period = wdata[10:0];
			for (int i = 0; i < 8; i++)
			begin
				if (addr == `HBPS_CH_CFG_BASE + 5'(i))
					next_cfg[i] = wdata[7:0];
				if (addr == `HBPS_DUTY_BASE + 5'(i))
				begin
					if (short_duty_format)
					begin
						if (wbe[1])
							next_duty[i][15:1] = {2'b00, wdata[14:8], 6'h00};
						if (wbe[0])
							next_duty[i][`HBPS_DUTY_POL_POS] = wdata[`HBPS_DUTY_POL_POS];
					end
					else
					begin
						if (wbe[1])
							next_duty[i][15:8] = wdata[15:8];
						if (wbe[0])
							next_duty[i][7:0] = wdata[7:0];
						if (wbe == 2'b11)
							next_duty[i] = {wdata[10:0], 4'h0, wdata[`HBPS_DUTY_POL_POS]};
					end
					if (i % 2 == 1)
						next_odd_written[i/2] = 1'b1;
				end
			end
		end
		if (rd)
		begin
			if (addr == `HBPS_CTRL_ADDR)
				next_rdata = {14'h0000, short_duty_format, side_sel_a};
			if (addr == `HBPS_PERIOD_ADDR)
				next_rdata = {5'h00, count};
			for (int i = 0; i < 8; i++)
			begin
				if (addr == `HBPS_CH_CFG_BASE + 5'(i))
					next_rdata = {8'h00, cfg[i]};
				if (addr == `HBPS_DUTY_BASE + 5'(i))
					next_rdata = duty[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Working register transfer.
	// ----------------------------------------------------------------
	always_comb
	begin
		next_wpol = wpol;
		for (int i = 0; i < 8; i++)
		begin
			next_wcfg[i] = wcfg[i];
			next_wduty[i] = wduty[i];
			if (period == 11'h000 || !ch_enabled(cfg[i]) || ch_en == 8'h00)
				next_wcfg[i] = cfg[i];
			else if (overflow)
				next_wcfg[i] = cfg[i];
		end
		for (int p = 0; p < 4; p++)
		begin
			for (int k = 0; k < 2; k++)
			begin
				if (period == 11'h000 || !ch_enabled(cfg[2*p+k]))
				begin
					next_wduty[2*p+k] = duty_value(duty[2*p+k]);
					next_wpol[2*p+k] = duty[2*p+k][`HBPS_DUTY_POL_POS];
				end
				else if (overflow && (!ch_dual[2*p+k] || odd_written[p]))
				begin
					next_wduty[2*p+k] = duty_value(duty[2*p+k]);
					next_wpol[2*p+k] = duty[2*p+k][`HBPS_DUTY_POL_POS];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode decode per channel.
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			ch_en[i] = ch_enabled(wcfg[i]) && period != 11'h000;
			ch_full[i] = omode(wcfg[i]) == hbps_pkg::HBPS_OM_FULL
				|| omode(wcfg[i]) == hbps_pkg::HBPS_OM_DUAL;
		end
		for (int p = 0; p < 4; p++)
		begin
			ch_dual[2*p] = ch_en[2*p] && ch_en[2*p+1]
				&& omode(wcfg[2*p]) == hbps_pkg::HBPS_OM_DUAL
				&& omode(wcfg[2*p+1]) == hbps_pkg::HBPS_OM_DUAL;
			ch_dual[2*p+1] = ch_dual[2*p];
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 8; i++)
			begin
				cfg[i] <= `HBPS_CFG_RESET;
				wcfg[i] <= `HBPS_CFG_RESET;
				duty[i] <= `HBPS_DUTY_RESET;
				wduty[i] <= 11'h000;
			end
			wpol <= 8'h00;
			odd_written <= 4'h0;
			side_sel_a <= 1'b0;
			short_duty_format <= 1'b0;
			period <= `HBPS_PERIOD_RESET;
			count <= 11'h000;
			rdata <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				cfg[i] <= next_cfg[i];
				wcfg[i] <= next_wcfg[i];
				duty[i] <= next_duty[i];
				wduty[i] <= next_wduty[i];
			end
			wpol <= next_wpol;
			odd_written <= next_odd_written;
			side_sel_a <= next_side_sel_a;
			short_duty_format <= next_short_duty_format;
			period <= next_period;
			count <= next_count;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Channels: index 2n is even pin set of pair n, 2n+1 the odd set.
	// ----------------------------------------------------------------
	// pair pin mapping
	for (genvar i = 0; i < 8; i++)
	begin : g_ch
		hbps_wave u_wave (
			.mclk(mclk),
			.arst_n(arst_n),
			.enable(ch_en[i]),
			.count(count),
			.duty(wduty[i]),
			.active(ch_active[i])
		);
		hbps_steer u_steer (
			.mclk(mclk),
			.arst_n(arst_n),
			.enable(ch_en[i]),
			.full_mode(ch_full[i]),
			.half_plus(omode(wcfg[i]) == hbps_pkg::HBPS_OM_HALF_PLUS),
			.polarity(wpol[i]),
			.side_sel_a(side_sel_a),
			.active(ch_active[i]),
			.plus_o(plus_o[i]),
			.plus_oe(plus_oe[i]),
			.minus_o(minus_o[i]),
			.minus_oe(minus_oe[i])
		);
	end
endmodule : hbps_top

// *** sim/hbps_chk.sv ***
// Checker for the ports of the H-bridge PWM output steering block.
`timescale 1ns/1ps
`include "hbps_params.svh"
module hbps_chk (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [`HBPS_ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [1:0] wbe,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic [7:0] plus_o,
	input wire logic [7:0] plus_oe,
	input wire logic [7:0] minus_o,
	input wire logic [7:0] minus_oe
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	logic [7:0] cfg [8];
	logic [7:0] next_cfg [8];
	logic [7:0] sgn;
	logic [7:0] next_sgn;
	logic side;
	logic next_side;
	logic [5:0] quiet;
	logic [5:0] next_quiet;
	logic calm;
	assign calm = quiet == 6'h3F;
	always_comb
	begin
		next_cfg = cfg;
		next_sgn = sgn;
		next_side = side;
		next_quiet = calm ? quiet : quiet + 6'h01;
		if (wr)
		begin
			next_quiet = 6'h00;
			if (addr < `HBPS_DUTY_BASE)
				next_cfg[addr[2:0]] = wdata[7:0];
			if (addr[4:3] == 2'h1 && wbe[0])
				next_sgn[addr[2:0]] = wdata[0];
			if (addr == `HBPS_CTRL_ADDR)
				next_side = wdata[0];
		end
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg <= '{default: 8'h00};
			sgn <= 8'h00;
			side <= 1'b0;
			quiet <= 6'h00;
		end
		else
		begin
			cfg <= next_cfg;
			sgn <= next_sgn;
			side <= next_side;
			quiet <= next_quiet;
		end
	end
	rst_release_a: assert property ($rose(arst_n) |-> plus_oe == 8'h00 && minus_oe == 8'h00)
		else $error("pin driven right after reset");
	rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside its cycle");
	unmapped_rd_a: assert property (rd && addr > `HBPS_PERIOD_ADDR |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	cfg_readback_a: assert property (wr && addr < `HBPS_DUTY_BASE ##2 rd && addr == $past(addr, 2)
		|=> {8'h00, rdata[7:0]} == ($past(wdata, 3) & 16'h00FF))
		else $error("config readback wrong");
	for (genvar i = 0; i < 8; i++)
	begin : g_ch
		off_release_a: assert property (calm && cfg[i][5:4] == 2'h0 |-> !plus_oe[i] && !minus_oe[i])
			else $error("disabled channel drives a pin");
		half_minus_a: assert property (calm && cfg[i][7:6] == 2'h0 && cfg[i][5:4] != 2'h0
			|-> minus_oe[i] && !plus_oe[i])
			else $error("half minus pins wrong");
		half_plus_a: assert property (calm && cfg[i][7:6] == 2'h1 && cfg[i][5:4] != 2'h0
			|-> plus_oe[i] && !minus_oe[i])
			else $error("half plus pins wrong");
		full_drive_a: assert property (calm && cfg[i][7] && cfg[i][5:4] != 2'h0
			|-> plus_oe[i] && minus_oe[i])
			else $error("full bridge pin released");
		static_level_a: assert property (calm && cfg[i][7:6] == 2'h2 && cfg[i][5:4] != 2'h0
			|-> (sgn[i] == side ? plus_o[i] : minus_o[i]) == !side)
			else $error("static pin level wrong");
	end
endmodule : hbps_chk
bind hbps_top hbps_chk i_hbps_chk (.mclk, .arst_n, .addr, .wdata, .wbe, .wr, .rd, .rdata,
	.plus_o, .plus_oe, .minus_o, .minus_oe);

// *** sim/hbps_coil.sv ***
// Coil load model that resolves the two pins of every channel.
`timescale 1ns/1ps
module hbps_coil (
	input wire logic mclk,
	input wire logic [7:0] plus_o,
	input wire logic [7:0] plus_oe,
	input wire logic [7:0] minus_o,
	input wire logic [7:0] minus_oe,
	output logic [7:0] pin_p,
	output logic [7:0] pin_m
);
	logic flt = 1'b0;
	always @(posedge mclk)
		flt <= ~flt;
	assign pin_p = (plus_o & plus_oe) | ({8{flt}} & ~plus_oe);
	assign pin_m = (minus_o & minus_oe) | ({8{flt}} & ~minus_oe);
endmodule : hbps_coil

// *** sim/tb_hbridge_pwm_output_steering.sv ***
// Self-checking testbench for the H-bridge PWM output steering block.
`timescale 1ns/1ps
`include "hbps_params.svh"
module tb_hbridge_pwm_output_steering;
	typedef struct packed {
		logic [2:0] ch;
		logic [7:0] cfg;
		logic [5:0] flg;
	} hbps_row_type;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic [1:0] wbe = 2'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic [7:0] plus_o;
	logic [7:0] plus_oe;
	logic [7:0] minus_o;
	logic [7:0] minus_oe;
	logic [7:0] pin_p;
	logic [7:0] pin_m;
	logic [15:0] v;
	int cnt = 0;
	int bad_count = 0;
	int checked = 0;
	// Flags: sign, side, plus driven, minus driven, plus is static, static level.
	hbps_row_type rows [8] = '{'{3'h0, 8'h10, 6'h04}, '{3'h1, 8'h50, 6'h28},
		'{3'h2, 8'h90, 6'h0F}, '{3'h3, 8'h90, 6'h2D}, '{3'h4, 8'h90, 6'h1C},
		'{3'h5, 8'h90, 6'h3E}, '{3'h6, 8'hD0, 6'h0F}, '{3'h7, 8'hC0, 6'h00}};
	always #5 mclk = ~mclk;
	hbps_top i_hbps_top (.mclk, .arst_n, .addr, .wdata, .wbe, .wr, .rd, .rdata,
		.plus_o, .plus_oe, .minus_o, .minus_oe);
	hbps_coil i_hbps_coil (.mclk, .plus_o, .plus_oe, .minus_o, .minus_oe, .pin_p, .pin_m);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wbe <= be;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg
	task automatic settle;
		repeat (80) @(posedge mclk);
		#1;
	endtask : settle
	task automatic count_lvl(input int ch, input logic on_minus, input logic lvl, output int n);
		n = 0;
		repeat (8)
		begin
			@(posedge mclk);
			#1;
			if ((on_minus ? pin_m[ch] : pin_p[ch]) === lvl)
				n++;
		end
	endtask : count_lvl
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		#1;
		chk("oe after reset", 16'h0000, {plus_oe, minus_oe});
		rd_reg(5'h1F);
		chk("unmapped read", `HBPS_UNMAPPED_READ, v);
		wr_reg(`HBPS_PERIOD_ADDR, 16'h0008);
		$display("reset test done");
		foreach (rows[k])
		begin
			wr_reg(`HBPS_CTRL_ADDR, {15'h0000, rows[k].flg[4]});
			wr_reg(`HBPS_DUTY_BASE + {2'h0, rows[k].ch}, {15'h0010, rows[k].flg[5]});
			wr_reg({2'h0, rows[k].ch}, {8'h00, rows[k].cfg});
			rd_reg({2'h0, rows[k].ch});
			chk("cfg readback", {8'h00, rows[k].cfg}, v & 16'h00FF);
			settle();
			chk("plus oe", 16'(rows[k].flg[3]), 16'(plus_oe[rows[k].ch]));
			chk("minus oe", 16'(rows[k].flg[2]), 16'(minus_oe[rows[k].ch]));
			if (rows[k].flg[3] && rows[k].flg[2])
				chk("static pin", 16'(rows[k].flg[0]),
					16'(rows[k].flg[1] ? pin_p[rows[k].ch] : pin_m[rows[k].ch]));
			wr_reg({2'h0, rows[k].ch}, 16'h0000);
			settle();
			$display("row %0d done", k);
		end
		wr_reg(`HBPS_CTRL_ADDR, 16'h0000);
		wr_reg(5'h00, 16'h00D0);
		wr_reg(5'h01, 16'h00D0);
		settle();
		chk("dual plus static", 16'h0001, 16'(pin_p[0]));
		wr_reg(`HBPS_DUTY_BASE, 16'h0021);
		wr_reg(`HBPS_DUTY_BASE, 16'h0020);
		wr_reg(`HBPS_DUTY_BASE, 16'h0021);
		settle();
		chk("even still old", 16'h0001, 16'(pin_p[0]));
		wr_reg(`HBPS_DUTY_BASE + 5'h01, 16'h0021);
		wr_reg(`HBPS_DUTY_BASE + 5'h01, 16'h0021);
		settle();
		chk("even now new", 16'h0001, 16'(pin_m[0]));
		$display("dual test done");
		wr_reg(5'h02, 16'h0010);
		wr_reg(`HBPS_DUTY_BASE + 5'h02, 16'h0003);
		settle();
		count_lvl(2, 1'b1, 1'b0, cnt);
		chk("long duty low cycles", 16'h0003, 16'(cnt));
		wr_reg(`HBPS_CTRL_ADDR, 16'h0002);
		wr_reg(`HBPS_DUTY_BASE + 5'h02, 16'h01FF, 2'h2);
		settle();
		count_lvl(2, 1'b1, 1'b0, cnt);
		chk("short duty low cycles", 16'h0004, 16'(cnt));
		$display("duty format test done");
		@(posedge mclk);
		arst_n <= 1'b0;
		#1;
		chk("oe in reset", 16'h0000, {plus_oe, minus_oe});
		@(posedge mclk);
		arst_n <= 1'b1;
		settle();
		chk("oe after second reset", 16'h0000, {plus_oe, minus_oe});
		$display("mid run reset done");
		final_report();
	end
endmodule : tb_hbridge_pwm_output_steering
